// File: strobe_mode_regs.svh
// Constants for the strobe-mode and auto-precharge timing block.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef STROBE_MODE_REGS_SVH
`define STROBE_MODE_REGS_SVH

`define REG_MODE3          4'h3
`define REG_MODE4          4'h4
`define REG_TIMING         4'h8
`define REG_STATUS         4'h9
`define MODE3_STROBE_BIT   5
`define MODE4_INVERT_BIT   11
`define MODE4_WRITE_CRC_ENABLE_BIT    0
`define MODE4_READ_CRC_ENABLE_BIT    1
`define CLK_PERIOD_NS      50
`define MODE_SET_DELAY_NS  400
`define MODE_SET_CYCLES    ((`MODE_SET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREAMBLE_PERIODS   2
`define TIMING_RESET       16'h0402
`define RDAP_GAP_READ      2
`define RDAP_GAP_PRE       1

`endif

// File: strobe_mode_pkg.sv
// Types shared by the strobe-mode block.
// Assumes nothing of its surroundings.
`default_nettype none
package strobe_mode_pkg;
    typedef enum logic [1:0] {
        CMD_NOP   = 2'h0,
        CMD_READ  = 2'h1,
        CMD_WRITE = 2'h3,
        CMD_OTHER = 2'h2
    } cmd_e;
    typedef enum logic [1:0] {
        ST_IDLE     = 2'h0,
        ST_PREAMBLE = 2'h1,
        ST_BURST    = 2'h3
    } strobe_state_e;
endpackage
`default_nettype wire

// File: strobe_gap_counter.sv
// Down counter giving the remaining precharge-period spacing.
// Assumes load and value come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module strobe_gap_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // Control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] value_i,
    // State
    output logic                  busy_o,
    output logic      [WIDTH-1:0] count_o
);
    logic [WIDTH-1:0] count_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_ff <= '0;
        end else if (load_i) begin
            count_ff <= value_i;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    assign busy_o  = (count_ff != '0);
    assign count_o = count_ff;
endmodule // strobe_gap_counter
`default_nettype wire

// File: strobe_mode_top.sv
// Read-strobe mode and auto-precharge precharge-period timer.
// Assumes commands decoded on CLK_I; data clock arrives unsynchronised.
// What this block does
// - Write auto precharge: precharge starts after write recovery, measured as without.
// - Read auto precharge: precharge starts at earliest point still reading whole burst.
// - Other-bank commands accepted during precharge period, no data collision.
// - Setting strobe bit drops hold pattern; pins high 450 ns after the write, one core clock past the 400 ns mode-set delay.
// - Mode register four CRC enables ignored while strobe mode active; its invert bit still used.
// - Strobe mode keeps read latency; clock-like strobe edge-aligned with data.
// - Strobe preamble runs two data-clock periods before first data.
// - No CRC in strobe mode; CRC enable bits ignored.
// - Writes unchanged in strobe mode; no write strobe.
// - Clearing strobe bit restores hold pattern 450 ns after the write, one core clock past the 400 ns mode-set delay.
// - Invert field drives pins one and three inverted strobe.
// - Strobe mode: idle pins 1111, held high in power-down or self refresh.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "strobe_mode_regs.svh"
module strobe_mode_top #(
    parameter int GAP_W = 8
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // Register port
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    // Command stream
    input  wire logic [1:0]  CMD_I,
    input  wire logic        AUTO_PRE_I,
    input  wire logic [1:0]  WRITE_KIND_I,
    input  wire logic        LOW_POWER_I,
    input  wire logic [3:0]  BURST_CLOCKS_I,
    // Data clock and error-detect pins
    input  wire logic        DATA_CLK_I,
    output logic      [3:0]  ERROR_DETECT_PINS_O,
    output logic      [3:0]  ERROR_DETECT_PINS_OE_O,
    // Status
    output logic             PRECHARGE_START_O,
    output logic             CRC_ACTIVE_O,
    output logic             READ_STROBE_MODE_O
);
    logic [15:0] mode_three_ff;
    logic [15:0] mode_four_ff;
    logic [15:0] timing_ff;
    logic [15:0] rdata_ff;
    logic [3:0]  mrd_cnt_ff;
    logic        strobe_mode_ff;
    logic [2:0]  dclk_sync_ff;
    logic [3:0]  hold_pattern_ff;
    logic [3:0]  pins_ff;
    logic [3:0]  burst_left_ff;
    logic [1:0]  pre_edges_ff;
    logic        strobe_phase_ff;
    logic        gap_load;
    logic [GAP_W-1:0] gap_value;
    logic        gap_busy;
    logic [GAP_W-1:0] gap_count;
    logic        gap_busy_q_ff;
    logic        dclk_rise;
    logic        req_bit;
    logic        invert_eff;
    strobe_mode_pkg::strobe_state_e state_ff;
    // Write kind only paces the controller; the device leaves it unread

    function automatic logic [GAP_W-1:0] widen(input logic [3:0] v);
        widen = {{(GAP_W-4){1'b0}}, v};
    endfunction

    // Register port, read data one cycle later
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_three_ff <= 16'h0000;
            mode_four_ff  <= 16'h0000;
            timing_ff     <= `TIMING_RESET;
        end else if (WR_I) begin
            case (ADDR_I)
                `REG_MODE3:  mode_three_ff <= WDATA_I;
                `REG_MODE4:  mode_four_ff  <= WDATA_I;
                `REG_TIMING: timing_ff     <= WDATA_I;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_ff <= 16'h0000;
        end else if (RD_I) begin
            case (ADDR_I)
                `REG_MODE3:  rdata_ff <= mode_three_ff;
                `REG_MODE4:  rdata_ff <= mode_four_ff;
                `REG_TIMING: rdata_ff <= timing_ff;
                `REG_STATUS: rdata_ff <= {6'h00, gap_busy, strobe_mode_ff, gap_count};
                default:     rdata_ff <= 16'h0000;
            endcase
        end
    end
    assign RDATA_O = rdata_ff;

    // Mode change takes effect after the mode-set delay
    assign req_bit = mode_three_ff[`MODE3_STROBE_BIT];
    // Count restarts if the bit flips back before the delay ends
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mrd_cnt_ff     <= 4'h0;
            strobe_mode_ff <= 1'b0;
        end else if (req_bit != strobe_mode_ff) begin
            if (mrd_cnt_ff == 4'(`MODE_SET_CYCLES - 1)) begin
                strobe_mode_ff <= req_bit;
                mrd_cnt_ff     <= 4'h0;
            end else begin
                mrd_cnt_ff <= mrd_cnt_ff + 4'h1;
            end
        end else begin
            mrd_cnt_ff <= 4'h0;
        end
    end
    assign READ_STROBE_MODE_O = strobe_mode_ff;

    // Only the mode four CRC enables are masked in strobe mode; the invert bit passes through
    assign invert_eff   = mode_four_ff[`MODE4_INVERT_BIT];
    assign CRC_ACTIVE_O = !strobe_mode_ff && (mode_four_ff[`MODE4_WRITE_CRC_ENABLE_BIT]
                          || mode_four_ff[`MODE4_READ_CRC_ENABLE_BIT]);

    // Data clock sampled; the second and third stages feed the edge detect
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            dclk_sync_ff <= 3'h0;
        end else begin
            dclk_sync_ff <= {dclk_sync_ff[1:0], DATA_CLK_I};
        end
    end
    assign dclk_rise = dclk_sync_ff[1] && !dclk_sync_ff[2];

    // Hold pattern toggles slowly in normal mode
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            hold_pattern_ff <= 4'h0;
        end else if (dclk_rise) begin
            hold_pattern_ff <= ~hold_pattern_ff;
        end
    end

    // Strobe sequencer: preamble then burst, writes never start it
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff        <= strobe_mode_pkg::ST_IDLE;
            pre_edges_ff    <= 2'h0;
            burst_left_ff   <= 4'h0;
            strobe_phase_ff <= 1'b0;
        end else begin
            case (state_ff)
                strobe_mode_pkg::ST_IDLE: begin
                    strobe_phase_ff <= 1'b0;
                    if (strobe_mode_ff && !LOW_POWER_I
                        && CMD_I == strobe_mode_pkg::CMD_READ) begin
                        state_ff      <= strobe_mode_pkg::ST_PREAMBLE;
                        pre_edges_ff  <= 2'(`PREAMBLE_PERIODS);
                        burst_left_ff <= BURST_CLOCKS_I;
                    end
                end
                strobe_mode_pkg::ST_PREAMBLE: begin
                    if (dclk_rise) begin
                        strobe_phase_ff <= ~strobe_phase_ff;
                        if (pre_edges_ff == 2'h1) begin
                            state_ff <= strobe_mode_pkg::ST_BURST;
                        end
                        pre_edges_ff <= pre_edges_ff - 2'h1;
                    end
                end
                strobe_mode_pkg::ST_BURST: begin
                    if (dclk_rise) begin
                        strobe_phase_ff <= ~strobe_phase_ff;
                        if (burst_left_ff <= 4'h1) begin
                            state_ff <= strobe_mode_pkg::ST_IDLE;
                        end
                        burst_left_ff <= burst_left_ff - 4'h1;
                    end
                end
                default: state_ff <= strobe_mode_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin drive
    // Idle high wins over strobe so power-down never glitches the pins
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pins_ff <= 4'h0;
        end else if (!strobe_mode_ff) begin
            pins_ff <= hold_pattern_ff;
        end else if (LOW_POWER_I || state_ff == strobe_mode_pkg::ST_IDLE) begin
            pins_ff <= 4'hF;
        end else if (invert_eff) begin
            pins_ff <= {~strobe_phase_ff, strobe_phase_ff,
                        ~strobe_phase_ff, strobe_phase_ff};
        end else begin
            pins_ff <= {4{strobe_phase_ff}};
        end
    end
    assign ERROR_DETECT_PINS_O    = pins_ff;
    assign ERROR_DETECT_PINS_OE_O = 4'hF;

    // Precharge-period start for auto-precharge accesses
    always_comb begin
        gap_load  = 1'b0;
        gap_value = '0;
        if (AUTO_PRE_I && CMD_I == strobe_mode_pkg::CMD_WRITE) begin
            gap_load  = 1'b1;
            gap_value = widen(timing_ff[15:12]);
        end else if (AUTO_PRE_I && CMD_I == strobe_mode_pkg::CMD_READ) begin
            gap_load  = 1'b1;
            gap_value = widen(BURST_CLOCKS_I);
        end
    end

    strobe_gap_counter #(
        .WIDTH (GAP_W)
    ) u_gap (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .load_i   (gap_load),
        .value_i  (gap_value),
        .busy_o   (gap_busy),
        .count_o  (gap_count)
    );

    // Other-bank commands are never blocked; timer only marks the boundary
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            gap_busy_q_ff <= 1'b0;
        end else begin
            gap_busy_q_ff <= gap_busy;
        end
    end
    assign PRECHARGE_START_O = gap_busy_q_ff && !gap_busy;

    // Checks beside the pin and timer logic
    AST_IDLE_HIGH: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff && LOW_POWER_I |=> pins_ff == 4'hF)
        else $error("pins not high in low power");
    AST_NORMAL_HOLD: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        !strobe_mode_ff |=> pins_ff == $past(hold_pattern_ff))
        else $error("hold pattern not driven");
    AST_MODE_DELAY: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $rose(req_bit) ##0 !strobe_mode_ff |-> ##[1:8] strobe_mode_ff || !req_bit)
        else $error("strobe mode entry late");
    AST_MODE_EXIT: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $fell(req_bit) ##0 strobe_mode_ff |-> ##[1:8] !strobe_mode_ff || req_bit)
        else $error("strobe mode exit late");
    AST_STROBE_ALIGN: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff && !invert_eff && state_ff != strobe_mode_pkg::ST_IDLE
        && !LOW_POWER_I |=> pins_ff == 4'h0 || pins_ff == 4'hF)
        else $error("strobe pins not in step");
    AST_PRECHARGE_POINT: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        gap_count == widen(4'h1) && !gap_load |=> PRECHARGE_START_O)
        else $error("precharge start missing");
    AST_CRC_OFF: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff |-> !CRC_ACTIVE_O)
        else $error("crc active in strobe mode");
    AST_INVERT: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff && invert_eff && state_ff != strobe_mode_pkg::ST_IDLE
        && !LOW_POWER_I |=> pins_ff[1] != pins_ff[0])
        else $error("invert pair wrong");
    AST_WRITE_NO_STROBE: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        state_ff == strobe_mode_pkg::ST_IDLE && CMD_I != strobe_mode_pkg::CMD_READ
        |=> state_ff == strobe_mode_pkg::ST_IDLE)
        else $error("strobe without read");
    AST_PREAMBLE: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        state_ff == strobe_mode_pkg::ST_IDLE ##1 state_ff == strobe_mode_pkg::ST_PREAMBLE
        |-> pre_edges_ff == 2'h2)
        else $error("preamble length wrong");
    AST_WRITE_RECOVERY: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        AUTO_PRE_I && CMD_I == strobe_mode_pkg::CMD_WRITE
        |=> gap_count == widen(timing_ff[15:12]))
        else $error("write recovery not loaded");
    AST_READ_BURST: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        AUTO_PRE_I && CMD_I == strobe_mode_pkg::CMD_READ |=> gap_count == widen($past(BURST_CLOCKS_I)))
        else $error("read precharge point wrong");

    COV_ENTER: cover property (@(posedge CLK_I) disable iff (!ARST_N_I) $rose(strobe_mode_ff));
    COV_BURST: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        state_ff == strobe_mode_pkg::ST_BURST);
    COV_PRE: cover property (@(posedge CLK_I) disable iff (!ARST_N_I) PRECHARGE_START_O);
    COV_INVERT: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff && invert_eff && state_ff == strobe_mode_pkg::ST_BURST);
    COV_LOW_POWER: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
        strobe_mode_ff && LOW_POWER_I && state_ff != strobe_mode_pkg::ST_IDLE);
endmodule // strobe_mode_top
`default_nettype wire

// File: ctrl_model.sv
// Controller-side model: command stream and free-running data clock.
// Assumes issue() is called right after a rising core-clock edge.
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
    // Clock
    input  wire logic       clk_i,
    // Command stream
    output logic      [1:0] cmd_o,
    output logic            auto_pre_o,
    output logic      [1:0] write_kind_o,
    output logic      [3:0] burst_o,
    // Data clock
    output logic            data_clk_o
);
    initial begin
        cmd_o = strobe_mode_pkg::CMD_NOP;
        auto_pre_o = 1'b0;
        write_kind_o = 2'h0;
        burst_o = 4'h0;
        data_clk_o = 1'b0;
    end
    // Data clock runs free on a real board, unrelated to the core clock
    // Rate never changes here, so no frequency-change sequence is needed
    always #200 data_clk_o = ~data_clk_o;
    // One command cycle, then 3 nop clocks; gaps of 4 or more clocks end after issue() returns
    task automatic issue(input logic [1:0] c, input logic ap, input logic [1:0] k,
                         input logic [3:0] b);
        cmd_o <= c;
        auto_pre_o <= ap;
        write_kind_o <= k;
        burst_o <= b;
        @(posedge clk_i);
        cmd_o <= strobe_mode_pkg::CMD_NOP;
        auto_pre_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // ctrl_model
`default_nettype wire

// File: test_strobe_mode_top.sv
// Bench for the strobe-mode block: register port, commands, pin checks.
// Assumes ctrl_model drives the command stream and the data clock.
`timescale 1ns/10ps
`default_nettype none
`include "strobe_mode_regs.svh"
module test_strobe_mode_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        low_power = 1'b0;
    logic [15:0] rdata;
    logic [1:0]  cmd;
    logic        auto_pre;
    logic [1:0]  write_kind;
    logic [3:0]  burst;
    logic        data_clk;
    logic [3:0]  pins;
    logic [3:0]  pins_oe;
    logic        pre_start;
    logic        crc_active;
    logic        strobe_mode;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          pulses;
    int          first;
    logic        toggled;
    logic        odd;
    logic [15:0] v;
    always #25 clk = ~clk;
    strobe_mode_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CMD_I(cmd), .AUTO_PRE_I(auto_pre),
        .WRITE_KIND_I(write_kind), .LOW_POWER_I(low_power), .BURST_CLOCKS_I(burst),
        .DATA_CLK_I(data_clk), .ERROR_DETECT_PINS_O(pins), .ERROR_DETECT_PINS_OE_O(pins_oe),
        .PRECHARGE_START_O(pre_start), .CRC_ACTIVE_O(crc_active),
        .READ_STROBE_MODE_O(strobe_mode));
    ctrl_model u_ctrl (.clk_i(clk), .cmd_o(cmd), .auto_pre_o(auto_pre),
        .write_kind_o(write_kind), .burst_o(burst), .data_clk_o(data_clk));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    // Pulses of the precharge start, first pulse cycle, non-idle and stray pin values
    task automatic watch(input int n, input logic inv);
        pulses = 0;
        first = -1;
        toggled = 1'b0;
        odd = 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            #1;
            if (pre_start === 1'b1) begin
                pulses++;
                if (first < 0) first = i;
            end
            if (pins !== 4'hF) toggled = 1'b1;
            if (pins !== 4'hF && (inv ? (pins !== 4'h5 && pins !== 4'hA) : (pins !== 4'h0))) begin
                odd = 1'b1;
            end
        end
    endtask
    task automatic t_reset();
        reg_rd(`REG_TIMING, v);
        chk(v, `TIMING_RESET);
        reg_rd(`REG_MODE3, v);
        chk(v, 16'h0000);
        reg_rd(4'h5, v);
        chk(v, 16'h0000);
        chk(16'(strobe_mode), 16'h0000);
        chk(16'(pins_oe), 16'h000F);
    endtask
    task automatic t_enter();
        reg_wr(`REG_MODE4, 16'h0003);
        #1 chk(16'(crc_active), 16'h0001);
        reg_wr(`REG_MODE3, 16'h0001 << `MODE3_STROBE_BIT);
        repeat (`MODE_SET_CYCLES - 1) @(posedge clk);
        #1 chk(16'(strobe_mode), 16'h0000);
        @(posedge clk);
        #1 chk(16'(strobe_mode), 16'h0001);
        @(posedge clk);
        #1 chk(16'(pins), 16'h000F);
        chk(16'(crc_active), 16'h0000);
        reg_wr(`REG_MODE4, 16'h0001 << `MODE4_INVERT_BIT);
        repeat (2) @(posedge clk);
        #1 chk(16'(pins), 16'h000F);
    endtask
    task automatic t_read();
        u_ctrl.issue(strobe_mode_pkg::CMD_READ, 1'b1, 2'h0, 4'h4);
        watch(100, 1'b1);
        chk(16'(pulses), 16'h0001);
        chk(16'(first), 16'h0001);
        chk(16'(toggled), 16'h0001);
        chk(16'(odd), 16'h0000);
        chk(16'(pins), 16'h000F);
    endtask
    task automatic t_write();
        // Recovery of 5 clocks lands the start after the command tail
        reg_wr(`REG_TIMING, 16'h5402);
        u_ctrl.issue(strobe_mode_pkg::CMD_WRITE, 1'b1, 2'h1, 4'h4);
        watch(30, 1'b0);
        chk(16'(pulses), 16'h0001);
        chk(16'(first), 16'h0002);
        chk(16'(toggled), 16'h0000);
    endtask
    // Power-down during the preamble, true strobe on all four pins
    task automatic t_low_power();
        reg_wr(`REG_MODE4, 16'h0000);
        u_ctrl.issue(strobe_mode_pkg::CMD_READ, 1'b0, 2'h0, 4'h4);
        low_power <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'(pins), 16'h000F);
        low_power <= 1'b0;
        watch(60, 1'b0);
        chk(16'(toggled), 16'h0001);
        chk(16'(odd), 16'h0000);
        chk(16'(pins), 16'h000F);
    endtask
    task automatic t_exit();
        reg_wr(`REG_MODE3, 16'h0000);
        repeat (`MODE_SET_CYCLES - 1) @(posedge clk);
        #1 chk(16'(strobe_mode), 16'h0001);
        @(posedge clk);
        #1 chk(16'(strobe_mode), 16'h0000);
        chk(16'(crc_active), 16'h0000);
        reg_wr(`REG_MODE4, 16'h0003);
        #1 chk(16'(crc_active), 16'h0001);
        u_ctrl.issue(strobe_mode_pkg::CMD_READ, 1'b0, 2'h0, 4'h4);
        watch(20, 1'b0);
        chk(16'(pulses), 16'h0000);
        chk(16'(toggled), 16'h0001);
        chk(16'(odd), 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_enter();
        t_read();
        t_low_power();
        t_write();
        t_exit();
        report_and_stop();
    end
    // Whole sequence needs about 270 cycles; allow about fifteen times that
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule // test_strobe_mode_top
`default_nettype wire
